/* design/flash_map_pkg.sv */
// constants and types for the flash array address map
package flash_map_pkg;
    // ------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 22;                     // 4 Mbyte array
    localparam int BLOCKS = 64;                     // 64 Kbyte blocks
    localparam int SECTORS = 1024;                  // 4 Kbyte sectors
    localparam int PAGE_BYTES = 256;                // program page
    localparam int SR_COUNT = 4;                    // security registers
    localparam logic [21:0] SECTOR_MASK = 22'h000FFF;
    localparam logic [21:0] BLOCK_MASK = 22'h00FFFF;
    localparam logic [21:0] CHIP_MASK = 22'h3FFFFF;
    localparam logic [21:0] SR_MASK = 22'h0000FF;
    localparam int SECTOR_LSB = 12;                 // sector index base
    localparam int BLOCK_LSB = 16;                  // block index base
    localparam int SR_IDX_LSB = 12;                 // register n at n*1000h
    localparam logic [7:0] ERASED = 8'hFF;
    // ------------------------------------------------------------
    // opcodes
    // ------------------------------------------------------------
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_PROG = 8'h02;
    localparam logic [7:0] OP_SEC_ERASE = 8'h20;
    localparam logic [7:0] OP_BLK_ERASE = 8'hD8;
    localparam logic [7:0] OP_CHIP_ERASE = 8'hC7;
    localparam logic [7:0] OP_SR_READ = 8'h48;
    localparam logic [7:0] OP_SR_PROG = 8'h42;
    localparam logic [7:0] OP_SR_ERASE = 8'h44;
    localparam logic [7:0] OP_SR_LOCK = 8'h31;
    localparam logic [7:0] OP_PARAM_READ = 8'h5A;   // read_discoverable_params_cmd
    // ------------------------------------------------------------
    // parameter space layout
    // ------------------------------------------------------------
    localparam logic [7:0] SIG_0 = 8'h53;
    localparam logic [7:0] SIG_1 = 8'h46;
    localparam logic [7:0] SIG_2 = 8'h44;
    localparam logic [7:0] SIG_3 = 8'h50;
    localparam logic [7:0] HDR_MINOR = 8'h06;
    localparam logic [7:0] HDR_MINOR_AT = 8'h04;
    localparam logic [7:0] HDR_LEN_AT = 8'h0B;      // table length, dwords
    localparam logic [7:0] HDR_PTR_AT = 8'h0C;      // table pointer
    localparam logic [7:0] HDR_RSVD_AT = 8'h10;     // undefined header room
    localparam logic [7:0] TABLE_AT = 8'h30;        // basic table start
    localparam logic [7:0] TABLE_END = 8'h6F;       // basic table end
    localparam logic [7:0] TABLE_DWORDS = 8'h10;
    localparam logic [7:0] RSVD_AT = 8'h70;         // reserved to FFh
    // ------------------------------------------------------------
    // states, one-hot
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_ERASE = 2'b10
    } state_type;
endpackage

/* design/param_rom_if.sv */
// carrier between the array controller and the parameter rom
`timescale 1ns/1ps
interface param_rom_if;
    logic [7:0] addr;   // byte address in parameter space
    logic [7:0] data;   // byte at that address
    modport ctrl (output addr, input data);
    modport rom (input addr, output data);
endinterface

/* design/param_rom.sv */
// read-only discoverable parameter space in security register 0
`timescale 1ns/1ps
module param_rom
(
    param_rom_if.rom port
);
    // ------------------------------------------------------------
    // byte lookup
    // ------------------------------------------------------------
    // signature, header and pointer; the table and all else read erased
    always_comb
    begin
        case (port.addr)
            8'h00: port.data = flash_map_pkg::SIG_0;
            8'h01: port.data = flash_map_pkg::SIG_1;
            8'h02: port.data = flash_map_pkg::SIG_2;
            8'h03: port.data = flash_map_pkg::SIG_3;
            flash_map_pkg::HDR_MINOR_AT: port.data = flash_map_pkg::HDR_MINOR;
            flash_map_pkg::HDR_LEN_AT: port.data = flash_map_pkg::TABLE_DWORDS;
            flash_map_pkg::HDR_PTR_AT: port.data = flash_map_pkg::TABLE_AT;
            default: port.data = flash_map_pkg::ERASED;
        endcase
    end
endmodule

/* design/flash_array_address_map.sv */
// flash array controller: main array, security registers, parameters
`timescale 1ns/1ps
module flash_array_address_map
#(
    parameter int AW = flash_map_pkg::ADDR_W
)
(
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    input wire logic i_cmd_valid,
    input wire logic [7:0] i_opcode,
    input wire logic [23:0] i_addr,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata,
    output logic o_rvalid,
    output logic o_reject,
    output logic o_busy,
    output logic [3:1] o_lock
);
    // ------------------------------------------------------------
    // storage and state
    // ------------------------------------------------------------
    logic [7:0] mem [0:(1<<AW)-1];      // main array
    logic [7:0] sreg [1:3][0:255];      // security registers 1..3
    flash_map_pkg::state_type state, next_state;
    logic [AW-1:0] base, next_base;     // erase start
    logic [AW-1:0] mask, next_mask;     // erase span
    logic [AW-1:0] ctr, next_ctr;       // erase walk
    logic er_sr, next_er_sr;            // erase hits a security reg
    logic [1:0] er_idx, next_er_idx;    // which security reg
    logic [7:0] next_rdata;
    logic next_rvalid, next_reject, next_busy;
    logic [3:1] next_lock;
    logic mem_we, sr_we;                // write strobes
    logic [AW-1:0] w_addr;
    logic [1:0] w_idx;
    logic [7:0] w_off, w_byte;
    logic [AW-1:0] a;                   // decoded array address
    logic [1:0] sr_idx;                 // decoded register number
    logic [7:0] sr_off;                 // decoded register offset
    param_rom_if rom_bus ();

    // 24-bit address onto 4 Mbyte array
    assign a = i_addr[AW-1:0];
    // register n at n*1000h, low byte offset
    assign sr_idx = i_addr[flash_map_pkg::SR_IDX_LSB +: 2];
    assign sr_off = i_addr[7:0];
    assign rom_bus.addr = sr_off;

    param_rom u_rom
    (
        .port(rom_bus)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        next_base = base;
        next_mask = mask;
        next_ctr = ctr;
        next_er_sr = er_sr;
        next_er_idx = er_idx;
        next_rdata = o_rdata;
        next_rvalid = 1'b0;
        next_reject = 1'b0;
        next_lock = o_lock;
        mem_we = 1'b0;
        sr_we = 1'b0;
        w_addr = a;
        w_idx = sr_idx;
        w_off = sr_off;
        w_byte = flash_map_pkg::ERASED;
        case (state)
            flash_map_pkg::ST_IDLE:
            begin
                if (i_cmd_valid)
                begin
                    next_ctr = '0;
                    next_er_sr = 1'b0;
                    next_er_idx = sr_idx;
                    case (i_opcode)
                        // plain array read
                        flash_map_pkg::OP_READ:
                        begin
                            next_rdata = mem[a];
                            next_rvalid = 1'b1;
                        end
                        flash_map_pkg::OP_PARAM_READ:
                        begin
                            next_rdata = rom_bus.data;
                            next_rvalid = 1'b1;
                        end
                        // register read; register 0 is the rom
                        flash_map_pkg::OP_SR_READ:
                        begin
                            next_rdata = (sr_idx == 2'h0) ? rom_bus.data
                                : sreg[sr_idx][sr_off];
                            next_rvalid = 1'b1;
                        end
                        flash_map_pkg::OP_PROG:
                        begin
                            mem_we = 1'b1;
                            w_byte = mem[a] & i_wdata;
                        end
                        flash_map_pkg::OP_SR_PROG:
                        begin
                            if (sr_idx == 2'h0 || o_lock[sr_idx])
                            begin
                                next_reject = 1'b1;
                            end
                            else
                            begin
                                sr_we = 1'b1;
                                w_byte = sreg[sr_idx][sr_off] & i_wdata;
                            end
                        end
                        flash_map_pkg::OP_SEC_ERASE:
                        begin
                            next_mask = flash_map_pkg::SECTOR_MASK[AW-1:0];
                            next_base = a & ~next_mask;
                            next_state = flash_map_pkg::ST_ERASE;
                        end
                        flash_map_pkg::OP_BLK_ERASE:
                        begin
                            next_mask = flash_map_pkg::BLOCK_MASK[AW-1:0];
                            next_base = a & ~next_mask;
                            next_state = flash_map_pkg::ST_ERASE;
                        end
                        flash_map_pkg::OP_CHIP_ERASE:
                        begin
                            next_mask = flash_map_pkg::CHIP_MASK[AW-1:0];
                            next_base = '0;
                            next_state = flash_map_pkg::ST_ERASE;
                        end
                        flash_map_pkg::OP_SR_ERASE:
                        begin
                            if (sr_idx == 2'h0 || o_lock[sr_idx])
                            begin
                                next_reject = 1'b1;
                            end
                            else
                            begin
                                next_mask = flash_map_pkg::SR_MASK[AW-1:0];
                                next_base = '0;
                                next_er_sr = 1'b1;
                                next_state = flash_map_pkg::ST_ERASE;
                            end
                        end
                        flash_map_pkg::OP_SR_LOCK:
                        begin
                            if (sr_idx == 2'h0)
                            begin
                                next_reject = 1'b1;
                            end
                            else
                            begin
                                next_lock[sr_idx] = 1'b1;
                            end
                        end
                        default: next_reject = 1'b1;
                    endcase
                end
            end
            flash_map_pkg::ST_ERASE:
            begin
                // walk the span writing erased bytes
                mem_we = ~er_sr;
                sr_we = er_sr;
                w_addr = base | ctr;
                w_idx = er_idx;
                w_off = ctr[7:0];
                w_byte = flash_map_pkg::ERASED;
                if (ctr == mask)
                begin
                    next_state = flash_map_pkg::ST_IDLE;
                end
                else
                begin
                    next_ctr = ctr + 1'b1;
                end
            end
            default: next_state = flash_map_pkg::ST_IDLE;
        endcase
        next_busy = (next_state != flash_map_pkg::ST_IDLE);
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // control state, synchronous reset
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_resetn)
        begin
            state <= flash_map_pkg::ST_IDLE;
            base <= '0;
            mask <= '0;
            ctr <= '0;
            er_sr <= 1'b0;
            er_idx <= 2'h0;
            o_rdata <= 8'h00;
            o_rvalid <= 1'b0;
            o_reject <= 1'b0;
            o_busy <= 1'b0;
            o_lock <= 3'h0;
        end
        else
        begin
            state <= next_state;
            base <= next_base;
            mask <= next_mask;
            ctr <= next_ctr;
            er_sr <= next_er_sr;
            er_idx <= next_er_idx;
            o_rdata <= next_rdata;
            o_rvalid <= next_rvalid;
            o_reject <= next_reject;
            o_busy <= next_busy;
            o_lock <= next_lock;
        end
    end

    // storage writes, no reset on cell contents
    always_ff @(posedge i_sys_clk)
    begin
        if (mem_we)
        begin
            mem[w_addr] <= w_byte;
        end
        if (sr_we && w_idx != 2'h0)
        begin
            sreg[w_idx][w_off] <= w_byte;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    logic [AW-1:0] chk_addr;    // address from the previous cycle
    logic [7:0] chk_old;        // content before program
    logic take;
    assign take = i_cmd_valid && state == flash_map_pkg::ST_IDLE;
    always_ff @(posedge i_sys_clk)
    begin
        chk_addr <= a;
        chk_old <= mem[a];
    end

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_resetn);

    prog_clear_a: assert property (
        take && i_opcode == flash_map_pkg::OP_PROG
        |=> (mem[chk_addr] & ~chk_old) == 8'h00)
        else $error("program raised a bit");
    lock_sticky_a: assert property (
        (o_lock & $past(o_lock)) == $past(o_lock))
        else $error("lock bit cleared");
    lock_refuse_a: assert property (
        take && i_opcode == flash_map_pkg::OP_SR_PROG && sr_idx != 2'h0
        && o_lock[sr_idx] |=> o_reject && !o_busy)
        else $error("locked register accepted program");
    param_ro_a: assert property (
        take && (i_opcode == flash_map_pkg::OP_SR_PROG
        || i_opcode == flash_map_pkg::OP_SR_ERASE) && sr_idx == 2'h0
        |=> o_reject && !o_busy)
        else $error("parameter space written");
    no_page_a: assert property (
        take && i_opcode == 8'h81 |=> o_reject && !o_busy)
        else $error("page erase accepted");
    signature_a: assert property (
        take && i_opcode == flash_map_pkg::OP_PARAM_READ
        && sr_off == 8'h00 |=> o_rvalid && o_rdata == 8'h53)
        else $error("signature byte wrong");
    pointer_a: assert property (
        take && i_opcode == flash_map_pkg::OP_PARAM_READ
        && sr_off == 8'h0C |=> o_rdata == 8'h30)
        else $error("table pointer wrong");
    reserved_ones_a: assert property (
        take && i_opcode == flash_map_pkg::OP_PARAM_READ
        && sr_off >= 8'h70 |=> o_rdata == 8'hFF)
        else $error("reserved byte not erased");
    sector_align_a: assert property (
        state == flash_map_pkg::ST_ERASE && !er_sr
        |-> (base & mask) == '0 && mask >= 'hFFF)
        else $error("erase span misaligned");
    sr_target_a: assert property (
        state == flash_map_pkg::ST_ERASE && er_sr
        |-> er_idx != 2'h0 && mask == 'hFF)
        else $error("register erase wrong target");
    sector_cov: cover property (take
        && i_opcode == flash_map_pkg::OP_SEC_ERASE ##1 o_busy);
    lock_cov: cover property (take
        && i_opcode == flash_map_pkg::OP_SR_LOCK ##1 o_lock != 3'h0);
    param_cov: cover property (take
        && i_opcode == flash_map_pkg::OP_PARAM_READ ##1 o_rvalid);
endmodule

/* design/unused_placeholder_none.sv */
// intentionally empty module-free file
`timescale 1ns/1ps

/* bench/flash_host_model.sv */
// host model that issues one flash command at a time
`timescale 1ns/1ps
module flash_host_model
(
    input wire logic i_sys_clk,
    output logic o_cmd_valid,
    output logic [7:0] o_opcode,
    output logic [23:0] o_addr,
    output logic [7:0] o_wdata
);
    // ----------------------------------------
    // request driver
    // ----------------------------------------
    // idle lines at time zero
    initial
    begin
        o_cmd_valid = 1'b0;
        o_opcode = 8'h00;
        o_addr = 24'h000000;
        o_wdata = 8'h00;
    end
    // one cycle strobe, then idle lines show the inverse, not stale data
    task automatic send(input logic [7:0] op, input logic [23:0] a,
        input logic [7:0] d);
        @(posedge i_sys_clk);
        o_cmd_valid <= 1'b1;
        o_opcode <= op;
        o_addr <= a;
        o_wdata <= d;
        @(posedge i_sys_clk);
        o_cmd_valid <= 1'b0;
        o_opcode <= ~op;
        o_addr <= ~a;
        o_wdata <= ~d;
    endtask
endmodule

/* bench/test_flash_array_address_map.sv */
// self-checking bench for the flash array controller
`timescale 1ns/1ps
module test_flash_array_address_map;
    // ----------------------------------------
    // signals and instances
    // ----------------------------------------
    localparam int AW = 16; // small array, chip erase 2^AW cycles
    logic i_sys_clk;
    logic i_resetn;
    logic cmd_valid;
    logic [7:0] opcode;
    logic [23:0] addr;
    logic [7:0] wdata;
    logic [7:0] o_rdata;
    logic o_rvalid;
    logic o_reject;
    logic o_busy;
    logic [3:1] o_lock;
    logic rv; // answer seen
    logic rj; // refusal seen
    logic [7:0] rd; // byte returned
    int bad_count;
    int checks;
    flash_host_model host (.i_sys_clk(i_sys_clk), .o_cmd_valid(cmd_valid),
        .o_opcode(opcode), .o_addr(addr), .o_wdata(wdata));
    flash_array_address_map #(.AW(AW)) uut (.i_sys_clk(i_sys_clk),
        .i_resetn(i_resetn), .i_cmd_valid(cmd_valid), .i_opcode(opcode),
        .i_addr(addr), .i_wdata(wdata), .o_rdata(o_rdata),
        .o_rvalid(o_rvalid), .o_reject(o_reject), .o_busy(o_busy),
        .o_lock(o_lock));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
            bad_count++;
        end
    endtask
    // verdict and end of run
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // issue a request and collect any answer over three cycles
    task automatic cmd(input logic [7:0] op, input logic [23:0] a,
        input logic [7:0] d);
        host.send(op, a, d);
        rv = 1'b0;
        rj = 1'b0;
        repeat (3)
        begin
            #1;
            if (o_rvalid === 1'b1)
            begin
                rv = 1'b1;
                rd = o_rdata;
            end
            if (o_reject === 1'b1)
                rj = 1'b1;
            @(posedge i_sys_clk);
        end
    endtask
    // read and compare the returned byte
    task automatic rdchk(input logic [7:0] op, input logic [23:0] a,
        input logic [7:0] exp);
        cmd(op, a, 8'h00);
        check({7'h00, rv}, 8'h01);
        check(rd, exp);
    endtask
    // request expected to be refused
    task automatic refuse(input logic [7:0] op, input logic [23:0] a);
        cmd(op, a, 8'h00);
        check({6'h00, rv, rj}, 8'h01);
    endtask
    // erase, then count busy cycles against the span
    task automatic erase(input logic [7:0] op, input logic [23:0] a,
        input int span);
        int n;
        int i;
        n = 0;
        host.send(op, a, 8'h00);
        for (i = 0; i < span + 8; i++)
        begin
            #1;
            if (o_busy === 1'b1)
                n++;
            else if (n > 0)
                break;
            @(posedge i_sys_clk);
        end
        if (i == span + 8)
        begin
            bad_count++;
            report_and_stop();
        end
        check({7'h00, n == span}, 8'h01);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    // chip erase clears both ends of the array
    task automatic chip_test();
        erase(flash_map_pkg::OP_CHIP_ERASE, 24'h000000, 2 ** AW);
        rdchk(flash_map_pkg::OP_READ, 24'h000000, 8'hFF);
        rdchk(flash_map_pkg::OP_READ, 24'h00FFFF, 8'hFF);
    endtask
    // program only clears bits
    task automatic prog_test();
        cmd(flash_map_pkg::OP_PROG, 24'h001234, 8'hA5);
        cmd(flash_map_pkg::OP_PROG, 24'h001234, 8'h0F);
        rdchk(flash_map_pkg::OP_READ, 24'h001234, 8'h05);
    endtask
    // sector erase stays inside its aligned 4 Kbyte range
    task automatic sector_test();
        cmd(flash_map_pkg::OP_PROG, 24'h002000, 8'h11);
        cmd(flash_map_pkg::OP_PROG, 24'h002FFF, 8'h22);
        cmd(flash_map_pkg::OP_PROG, 24'h003000, 8'h33);
        cmd(flash_map_pkg::OP_PROG, 24'h001FFF, 8'h44);
        erase(flash_map_pkg::OP_SEC_ERASE, 24'h002ABC, 4096);
        rdchk(flash_map_pkg::OP_READ, 24'h002000, 8'hFF);
        rdchk(flash_map_pkg::OP_READ, 24'h002FFF, 8'hFF);
        rdchk(flash_map_pkg::OP_READ, 24'h003000, 8'h33);
        rdchk(flash_map_pkg::OP_READ, 24'h001FFF, 8'h44);
        refuse(8'h81, 24'h002000);
    endtask
    // security registers apart from each other and the array
    task automatic secreg_test();
        erase(flash_map_pkg::OP_SR_ERASE, 24'h001000, 256);
        erase(flash_map_pkg::OP_SR_ERASE, 24'h002000, 256);
        erase(flash_map_pkg::OP_SR_ERASE, 24'h003000, 256);
        cmd(flash_map_pkg::OP_SR_PROG, 24'h002010, 8'h3C);
        rdchk(flash_map_pkg::OP_SR_READ, 24'h002010, 8'h3C);
        rdchk(flash_map_pkg::OP_SR_READ, 24'h001010, 8'hFF);
        rdchk(flash_map_pkg::OP_SR_READ, 24'h003010, 8'hFF);
        rdchk(flash_map_pkg::OP_READ, 24'h003000, 8'h33);
    endtask
    // lock bit set, then program and erase refused
    task automatic lock_test();
        cmd(flash_map_pkg::OP_SR_LOCK, 24'h002000, 8'h00);
        check({5'h00, o_lock}, 8'h02);
        refuse(flash_map_pkg::OP_SR_PROG, 24'h002010);
        refuse(flash_map_pkg::OP_SR_ERASE, 24'h002000);
        rdchk(flash_map_pkg::OP_SR_READ, 24'h002010, 8'h3C);
        check({5'h00, o_lock}, 8'h02);
    endtask
    // parameter space layout and read-only behaviour
    task automatic param_test();
        rdchk(flash_map_pkg::OP_PARAM_READ, 24'h000000, 8'h53);
        rdchk(flash_map_pkg::OP_PARAM_READ, 24'h000001, 8'h46);
        rdchk(flash_map_pkg::OP_PARAM_READ, 24'h000002, 8'h44);
        rdchk(flash_map_pkg::OP_PARAM_READ, 24'h000003, 8'h50);
        rdchk(flash_map_pkg::OP_PARAM_READ, 24'h000004, 8'h06);
        rdchk(flash_map_pkg::OP_PARAM_READ, 24'h00000B, 8'h10);
        rdchk(flash_map_pkg::OP_PARAM_READ, 24'h00000C, 8'h30);
        rdchk(flash_map_pkg::OP_PARAM_READ, 24'h000030, 8'hFF);
        rdchk(flash_map_pkg::OP_PARAM_READ, 24'h000010, 8'hFF);
        rdchk(flash_map_pkg::OP_PARAM_READ, 24'h000070, 8'hFF);
        rdchk(flash_map_pkg::OP_PARAM_READ, 24'h0000FF, 8'hFF);
        rdchk(flash_map_pkg::OP_SR_READ, 24'h000000, 8'h53);
        refuse(flash_map_pkg::OP_SR_PROG, 24'h000000);
        refuse(flash_map_pkg::OP_SR_ERASE, 24'h000000);
        refuse(flash_map_pkg::OP_SR_LOCK, 24'h000000);
        rdchk(flash_map_pkg::OP_PARAM_READ, 24'h000000, 8'h53);
    endtask
    // block erase, requests ignored while busy, reset aborts the walk
    task automatic block_test();
        host.send(flash_map_pkg::OP_BLK_ERASE, 24'h000000, 8'h00);
        repeat (3) @(posedge i_sys_clk);
        #1;
        check({7'h00, o_busy}, 8'h01);
        cmd(flash_map_pkg::OP_READ, 24'h001234, 8'h00);
        check({6'h00, rv, rj}, 8'h00);
        @(posedge i_sys_clk);
        i_resetn <= 1'b0;
        repeat (20) @(posedge i_sys_clk);
        #1;
        check({4'h0, o_busy, o_lock}, 8'h00);
        @(posedge i_sys_clk);
        i_resetn <= 1'b1;
    endtask
    // ----------------------------------------
    // clock and main sequence
    // ----------------------------------------
    // 200 MHz clock
    initial
    begin
        i_sys_clk = 1'b0;
        forever #2.5 i_sys_clk = ~i_sys_clk;
    end
    // reset, then each scenario in turn
    initial
    begin
        bad_count = 0;
        checks = 0;
        i_resetn = 1'b0;
        repeat (20) @(posedge i_sys_clk);
        i_resetn <= 1'b1;
        chip_test();
        prog_test();
        sector_test();
        secreg_test();
        lock_test();
        param_test();
        block_test();
        report_and_stop();
    end
endmodule
